//--- verilog/smrd_consts.svh
// constants for the synthesizer input mux, reset sequencer and dividers
`ifndef SMRD_CONSTS_SVH
`define SMRD_CONSTS_SVH
`define SMRD_CLK_MHZ 25
`define SMRD_RST_TIMER_US 20
`define SMRD_RST_TIMER_CYC ((`SMRD_RST_TIMER_US * `SMRD_CLK_MHZ) < 1 ? 1 : (`SMRD_RST_TIMER_US * `SMRD_CLK_MHZ))
`define SMRD_CAL_CYC 64
`define SMRD_MUX_AUTO_A 2'h0
`define SMRD_MUX_AUTO_B 2'h1
`define SMRD_MUX_FORCE_PRI 2'h2
`define SMRD_MUX_PIN 2'h3
`define SMRD_LOSS_CYC 16
`define SMRD_DEF_MUX_CTRL 2'h0
`define SMRD_DEF_REF_DIV 4'h0
`define SMRD_DEF_IN_DIV 14'h0000
`define SMRD_DEF_FB_DIV_A 8'h00
`define SMRD_DEF_FB_DIV_B 10'h000
`define SMRD_DEF_CMOS_FAST 1'h1
`endif

//--- verilog/smrd_pkg.sv
// types for the synthesizer control block
package smrd_pkg;
  typedef enum logic [4:0] {
    SMRD_ST_RESET = 5'h01,
    SMRD_ST_STAB = 5'h02,
    SMRD_ST_CAL = 5'h04,
    SMRD_ST_RUN = 5'h08,
    SMRD_ST_SOFT = 5'h10
  } smrd_state_t;
  typedef struct packed {
    logic [1:0] mux_ctrl;
    logic [3:0] ref_div;
    logic [13:0] in_div;
    logic [7:0] fb_div_a;
    logic [9:0] fb_div_b;
    logic cmos_fast;
  } smrd_cfg_t;
endpackage

//--- verilog/smrd_ctrl.sv
// synthesizer control: reference mux, reset and calibration sequence, divider counters
// Function
// - field 11: select pin low picks primary, high picks secondary
// - automatic switching prefers primary over secondary
// - normal operation only while power-down and reset pins are high
// - either pin low puts and holds the device in reset
// - leaving pin reset reloads all configuration defaults before calibration
// - software reset keeps registers and calibrates with current contents
// - software reset bit rests low; high then low triggers reset
// - after reset wait for valid supplies and timer before calibrating
// - all outputs held in reset while calibration runs
// - primary reference divider is 4-bit, ratio 1 to 16
// - input divider after mux is 14-bit, ratio 1 to 16384
// - feedback divider is 8-bit then 10-bit cascaded counters
// - first prescaler feeds outputs 0,1,4,5 and feedback; second 2,3,6,7
// - CMOS mode upper outputs drive two in-phase single-ended signals
// - register bit selects fast or reduced CMOS edge rate
// - reference mux suppresses glitches in auto and manual modes
// - mode bit 1 low selects automatically, primary first, ignoring select inputs
`timescale 1ns/1ns
`include "smrd_consts.svh"
module smrd_ctrl #(
  parameter int RST_TIMER_CYC = `SMRD_RST_TIMER_CYC,
  parameter int CAL_CYC = `SMRD_CAL_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_pin,
  input wire logic reset_pin,
  input wire logic supplies_valid,
  input wire logic soft_reset_bit,
  input wire logic cfg_wr,
  input wire smrd_pkg::smrd_cfg_t cfg_wdata,
  input wire logic ref_sel_pin,
  input wire logic primary_reference,
  input wire logic secondary_reference,
  input wire logic vco_clk,
  input wire logic [7:0] cmos_mode,
  output smrd_pkg::smrd_cfg_t cfg_q,
  output logic [1:0] state_q,
  output logic outputs_in_reset,
  output logic sel_secondary,
  output logic mux_ref_out,
  output logic pfd_ref_out,
  output logic pfd_fb_out,
  output logic first_prescaler_out,
  output logic [7:0] out_div_src,
  output logic [15:0] out_pins,
  output logic [7:0] slew_fast
);
  // ==========================================================
  // reset and calibration sequencer
  smrd_pkg::smrd_state_t state_ff, nxt_state;
  smrd_pkg::smrd_cfg_t cfg_ff;
  logic soft_ff;
  logic [31:0] cnt_ff;
  wire pins_high = power_down_pin & reset_pin;
  wire soft_fall = soft_ff & ~soft_reset_bit;
  wire timer_done = (cnt_ff >= 32'(RST_TIMER_CYC - 1));
  wire cal_done = (cnt_ff >= 32'(CAL_CYC - 1));
  // next state selection
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      smrd_pkg::SMRD_ST_RESET: if (pins_high) nxt_state = smrd_pkg::SMRD_ST_STAB;
      smrd_pkg::SMRD_ST_STAB: if (timer_done && supplies_valid) nxt_state = smrd_pkg::SMRD_ST_CAL;
      smrd_pkg::SMRD_ST_CAL: if (cal_done) nxt_state = smrd_pkg::SMRD_ST_RUN;
      smrd_pkg::SMRD_ST_RUN: if (soft_fall) nxt_state = smrd_pkg::SMRD_ST_SOFT;
      smrd_pkg::SMRD_ST_SOFT: nxt_state = smrd_pkg::SMRD_ST_STAB;
      default: nxt_state = smrd_pkg::SMRD_ST_RESET;
    endcase
    if (!pins_high) nxt_state = smrd_pkg::SMRD_ST_RESET;
  end
  // state, timer and soft bit history
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= smrd_pkg::SMRD_ST_RESET;
      cnt_ff <= 32'h0;
      soft_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (nxt_state != state_ff) ? 32'h0 : cnt_ff + 32'h1;
      soft_ff <= soft_reset_bit;
    end
  end
  // configuration bank: defaults in pin reset, kept across soft reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ff <= '{`SMRD_DEF_MUX_CTRL, `SMRD_DEF_REF_DIV, `SMRD_DEF_IN_DIV,
                 `SMRD_DEF_FB_DIV_A, `SMRD_DEF_FB_DIV_B, `SMRD_DEF_CMOS_FAST};
    end else if (state_ff == smrd_pkg::SMRD_ST_RESET) begin
      cfg_ff <= '{`SMRD_DEF_MUX_CTRL, `SMRD_DEF_REF_DIV, `SMRD_DEF_IN_DIV,
                 `SMRD_DEF_FB_DIV_A, `SMRD_DEF_FB_DIV_B, `SMRD_DEF_CMOS_FAST};
    end else if (cfg_wr) begin
      cfg_ff <= cfg_wdata;
    end
  end
  assign cfg_q = cfg_ff;
  assign state_q = (state_ff == smrd_pkg::SMRD_ST_RUN) ? 2'h3 :
                   (state_ff == smrd_pkg::SMRD_ST_CAL) ? 2'h2 :
                   (state_ff == smrd_pkg::SMRD_ST_RESET) ? 2'h0 : 2'h1;
  wire out_rst = (state_ff != smrd_pkg::SMRD_ST_RUN);
  assign outputs_in_reset = out_rst;
  // ==========================================================
  // reference divider on the primary input
  logic [3:0] rdiv_ff;
  logic rdiv_tick_ff;
  logic pri_d_ff;
  wire pri_rise = primary_reference & ~pri_d_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdiv_ff <= 4'h0;
      rdiv_tick_ff <= 1'h0;
      pri_d_ff <= 1'h0;
    end else begin
      pri_d_ff <= primary_reference;
      rdiv_tick_ff <= 1'h0;
      if (pri_rise) begin
        rdiv_ff <= (rdiv_ff >= cfg_ff.ref_div) ? 4'h0 : rdiv_ff + 4'h1;
        rdiv_tick_ff <= (rdiv_ff >= cfg_ff.ref_div);
      end
    end
  end
  // ==========================================================
  // smart mux: activity watch, selection and glitch-free switch
  logic sec_d_ff;
  logic [4:0] pri_idle_ff;
  logic sel_ff;
  logic mux_out_ff;
  wire sec_rise = secondary_reference & ~sec_d_ff;
  wire pri_alive = (pri_idle_ff < 5'(`SMRD_LOSS_CYC));
  wire manual = cfg_ff.mux_ctrl[1];
  wire want_sec = !manual ? !pri_alive :
                  (cfg_ff.mux_ctrl == `SMRD_MUX_PIN) ? ref_sel_pin : 1'b0;
  wire div_pri = (cfg_ff.ref_div == 4'h0) ? primary_reference : rdiv_tick_ff;
  wire both_low = ~div_pri & ~secondary_reference;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_d_ff <= 1'h0;
      pri_idle_ff <= 5'h0;
      sel_ff <= 1'h0;
      mux_out_ff <= 1'h0;
    end else begin
      sec_d_ff <= secondary_reference;
      pri_idle_ff <= pri_rise ? 5'h0 : (pri_alive ? pri_idle_ff + 5'h1 : pri_idle_ff);
      if (both_low) sel_ff <= want_sec;
      mux_out_ff <= sel_ff ? secondary_reference : div_pri;
    end
  end
  assign sel_secondary = sel_ff;
  assign mux_ref_out = mux_out_ff;
  // ==========================================================
  // input divider after the mux feeding the phase detector
  logic [13:0] mdiv_ff;
  logic mux_d_ff;
  logic pfd_ref_ff;
  wire mux_rise = mux_out_ff & ~mux_d_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdiv_ff <= 14'h0;
      mux_d_ff <= 1'h0;
      pfd_ref_ff <= 1'h0;
    end else begin
      mux_d_ff <= mux_out_ff;
      pfd_ref_ff <= 1'h0;
      if (mux_rise) begin
        mdiv_ff <= (mdiv_ff >= cfg_ff.in_div) ? 14'h0 : mdiv_ff + 14'h1;
        pfd_ref_ff <= (mdiv_ff >= cfg_ff.in_div);
      end
    end
  end
  assign pfd_ref_out = pfd_ref_ff;
  // ==========================================================
  // feedback divider: first prescaler edge, 8-bit then 10-bit stage
  logic vco_d_ff;
  logic [7:0] fba_ff;
  logic [9:0] fbb_ff;
  logic pfd_fb_ff;
  logic psa_ff;
  wire vco_rise = vco_clk & ~vco_d_ff;
  wire fba_wrap = (fba_ff >= cfg_ff.fb_div_a);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vco_d_ff <= 1'h0;
      fba_ff <= 8'h0;
      fbb_ff <= 10'h0;
      pfd_fb_ff <= 1'h0;
      psa_ff <= 1'h0;
    end else begin
      vco_d_ff <= vco_clk;
      psa_ff <= vco_rise;
      pfd_fb_ff <= 1'h0;
      if (vco_rise) begin
        fba_ff <= fba_wrap ? 8'h0 : fba_ff + 8'h1;
        if (fba_wrap) begin
          fbb_ff <= (fbb_ff >= cfg_ff.fb_div_b) ? 10'h0 : fbb_ff + 10'h1;
          pfd_fb_ff <= (fbb_ff >= cfg_ff.fb_div_b);
        end
      end
    end
  end
  assign pfd_fb_out = pfd_fb_ff;
  assign first_prescaler_out = psa_ff;
  // ==========================================================
  // output routing, CMOS pairs and edge rate
  logic [15:0] pins_ff;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_out
      localparam bit USE_A = (g % 4) < 2;
      assign out_div_src[g] = USE_A ? 1'b0 : 1'b1;
      wire lvl = USE_A ? psa_ff : vco_d_ff;
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pins_ff[2*g+1:2*g] <= 2'h0;
        end else if (out_rst) begin
          pins_ff[2*g+1:2*g] <= 2'h0;
        end else if (g >= 4 && cmos_mode[g]) begin
          pins_ff[2*g+1:2*g] <= {lvl, lvl};
        end else begin
          pins_ff[2*g+1:2*g] <= {~lvl, lvl};
        end
      end
      assign slew_fast[g] = cfg_ff.cmos_fast & cmos_mode[g] & (g >= 4);
    end
  endgenerate
  assign out_pins = pins_ff;
  // ==========================================================
  // checks
  // sequencer: pin reset, normal mode and the step into calibration
  property p_hold_reset;
    @(posedge clk) disable iff (sys_rst) !pins_high |=> state_ff == smrd_pkg::SMRD_ST_RESET;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("pin low did not hold reset");
  property p_run_pins;
    @(posedge clk) disable iff (sys_rst) state_ff == smrd_pkg::SMRD_ST_RUN |-> $past(pins_high);
  endproperty
  a_run_pins: assert property (p_run_pins) else $error("ran with pin low");
  sequence s_stab_ok;
    state_ff == smrd_pkg::SMRD_ST_STAB && timer_done && supplies_valid && pins_high;
  endsequence
  property p_cal_start;
    @(posedge clk) disable iff (sys_rst) s_stab_ok |=> state_ff == smrd_pkg::SMRD_ST_CAL;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");
  property p_no_early_cal;
    @(posedge clk) disable iff (sys_rst)
      $rose(state_ff == smrd_pkg::SMRD_ST_CAL) |-> $past(supplies_valid);
  endproperty
  a_no_early_cal: assert property (p_no_early_cal) else $error("calibrated without valid supplies");
  property p_cal_quiet;
    @(posedge clk) disable iff (sys_rst) state_ff == smrd_pkg::SMRD_ST_CAL |=> pins_ff == 16'h0;
  endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("output active during calibration");
  property p_out_start;
    @(posedge clk) disable iff (sys_rst)
      state_ff == smrd_pkg::SMRD_ST_CAL && cal_done && pins_high |=> !outputs_in_reset;
  endproperty
  a_out_start: assert property (p_out_start) else $error("outputs not released after calibration");
  property p_defaults;
    @(posedge clk) disable iff (sys_rst) state_ff == smrd_pkg::SMRD_ST_RESET |=> cfg_ff.in_div == `SMRD_DEF_IN_DIV;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not reloaded");
  property p_soft_keep;
    @(posedge clk) disable iff (sys_rst)
      state_ff == smrd_pkg::SMRD_ST_SOFT && !cfg_wr |=> $stable(cfg_ff);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset lost settings");
  property p_soft_trig;
    @(posedge clk) disable iff (sys_rst)
      state_ff == smrd_pkg::SMRD_ST_RUN && soft_fall && pins_high |=> state_ff == smrd_pkg::SMRD_ST_SOFT ##1
      state_ff == smrd_pkg::SMRD_ST_STAB || !pins_high;
  endproperty
  a_soft_trig: assert property (p_soft_trig) else $error("soft reset sequence ignored");
  // reference mux: forced, pin and automatic selection
  property p_force_pri;
    @(posedge clk) disable iff (sys_rst) manual && cfg_ff.mux_ctrl != `SMRD_MUX_PIN && both_low |=> !sel_ff;
  endproperty
  a_force_pri: assert property (p_force_pri) else $error("forced primary not selected");
  property p_pin_sel;
    @(posedge clk) disable iff (sys_rst)
      cfg_ff.mux_ctrl == `SMRD_MUX_PIN && both_low |=> sel_ff == $past(ref_sel_pin);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("select pin not followed");
  property p_glitch;
    @(posedge clk) disable iff (sys_rst) $changed(sel_ff) |-> $past(both_low);
  endproperty
  a_glitch: assert property (p_glitch) else $error("switch while a reference high");
  property p_prio;
    @(posedge clk) disable iff (sys_rst) !manual && pri_alive && both_low |=> !sel_ff;
  endproperty
  a_prio: assert property (p_prio) else $error("primary not preferred");
  // output stage: upper cmos pairs stay in phase
  property p_cmos_pair;
    @(posedge clk) disable iff (sys_rst) cmos_mode[7:4] == 4'hf |=>
      {pins_ff[15], pins_ff[13], pins_ff[11], pins_ff[9]} == {pins_ff[14], pins_ff[12], pins_ff[10], pins_ff[8]};
  endproperty
  a_cmos_pair: assert property (p_cmos_pair) else $error("cmos pair out of phase");
endmodule // smrd_ctrl

//--- sim/smrd_ref_src.sv
// reference clock source model: primary, secondary and vco clocks for the control block
`timescale 1ns/1ns
module smrd_ref_src (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pri_run,
  output logic primary_reference,
  output logic secondary_reference,
  output logic vco_clk
);
  logic [1:0] ph_ff;
  // =========================================
  // phase counter
  // all sources share a period of four system clocks, slow enough to be sampled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ph_ff <= 2'h0;
    else
      ph_ff <= ph_ff + 2'h1;
  end
  // equal frequencies, secondary a quarter period early; a dead primary sits low
  assign primary_reference = pri_run & ph_ff[1];
  assign secondary_reference = ph_ff[1] ^ ph_ff[0];
  assign vco_clk = ph_ff[1];
endmodule // smrd_ref_src

//--- sim/smrd_ctrl_bench.sv
// self-checking bench for the synthesizer control block
`timescale 1ns/1ns
`include "smrd_consts.svh"
module smrd_ctrl_bench;
  logic clk, sys_rst, power_down_pin, reset_pin, supplies_valid, soft_reset_bit, cfg_wr, ref_sel_pin, pri_run;
  logic primary_reference, secondary_reference, vco_clk;
  logic [7:0] cmos_mode, out_div_src, slew_fast;
  smrd_pkg::smrd_cfg_t cfg_wdata, cfg_q, def_cfg, plan;
  logic [1:0] state_q;
  logic outputs_in_reset, sel_secondary, mux_ref_out, pfd_ref_out, pfd_fb_out, first_prescaler_out;
  logic [15:0] out_pins;
  int fail_count = 0;
  int n_compared = 0;
  int n_ref, n_fb, n_ps, n_mux;
  // =========================================
  // design and source model
  smrd_ctrl #(.RST_TIMER_CYC(4), .CAL_CYC(4)) dut (
    .clk(clk), .sys_rst(sys_rst), .power_down_pin(power_down_pin), .reset_pin(reset_pin),
    .supplies_valid(supplies_valid), .soft_reset_bit(soft_reset_bit), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .ref_sel_pin(ref_sel_pin), .primary_reference(primary_reference), .secondary_reference(secondary_reference),
    .vco_clk(vco_clk), .cmos_mode(cmos_mode), .cfg_q(cfg_q), .state_q(state_q), .outputs_in_reset(outputs_in_reset),
    .sel_secondary(sel_secondary), .mux_ref_out(mux_ref_out), .pfd_ref_out(pfd_ref_out), .pfd_fb_out(pfd_fb_out),
    .first_prescaler_out(first_prescaler_out), .out_div_src(out_div_src), .out_pins(out_pins), .slew_fast(slew_fast));
  smrd_ref_src src (.clk(clk), .sys_rst(sys_rst), .pri_run(pri_run), .primary_reference(primary_reference),
    .secondary_reference(secondary_reference), .vco_clk(vco_clk));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // =========================================
  // tasks
  task automatic end_of_test();
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(input smrd_pkg::smrd_cfg_t got, input smrd_pkg::smrd_cfg_t exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t config %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // which 0 waits on the state code, 1 on the mux selection
  task automatic wait_sig(input int which, input logic [1:0] v);
    int k;
    k = 0;
    while ((which ? {1'b0, sel_secondary} : state_q) !== v) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 200) begin
        fail_count++;
        $display("[ERR] %0t wait for %0d timed out", $time, which);
        end_of_test();
      end
    end
    n_compared++;
  endtask
  task automatic wr(input smrd_pkg::smrd_cfg_t v);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cyc(2);
    #1;
  endtask
  // counts divider pulses and checks the cmos pairs stay in phase meanwhile
  task automatic count_pulses(input int n);
    n_ref = 0;
    n_fb = 0;
    n_ps = 0;
    n_mux = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_mux += mux_ref_out;
      n_ref += pfd_ref_out;
      n_fb += pfd_fb_out;
      n_ps += first_prescaler_out;
      chk_val({out_pins[15], out_pins[13], out_pins[11], out_pins[9]}, {out_pins[14], out_pins[12], out_pins[10], out_pins[8]});
      chk_val({out_pins[7], out_pins[5], out_pins[3], out_pins[1]}, {~out_pins[6], ~out_pins[4], ~out_pins[2], ~out_pins[0]});
    end
  endtask
  // =========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    power_down_pin = 1'b0;
    reset_pin = 1'b0;
    supplies_valid = 1'b0;
    soft_reset_bit = 1'b0;
    cfg_wr = 1'b0;
    cfg_wdata = '0;
    ref_sel_pin = 1'b1;
    pri_run = 1'b1;
    cmos_mode = 8'hf0;
    def_cfg = '{`SMRD_DEF_MUX_CTRL, `SMRD_DEF_REF_DIV, `SMRD_DEF_IN_DIV, `SMRD_DEF_FB_DIV_A, `SMRD_DEF_FB_DIV_B,
      `SMRD_DEF_CMOS_FAST};
    plan = '{2'h2, 4'h1, 14'h0001, 8'h01, 10'h001, 1'b0};
    cyc(4);
    sys_rst <= 1'b0;
    power_down_pin <= 1'b1;
    wr(plan);
    chk_val(state_q, 2'h0);
    chk_val(outputs_in_reset, 1'b1);
    chk_val(out_pins, 16'h0000);
    chk_cfg(cfg_q, def_cfg);
    // leave reset with supplies not yet valid
    @(posedge clk);
    reset_pin <= 1'b1;
    cyc(20);
    #1;
    chk_val(state_q, 2'h1);
    @(posedge clk);
    supplies_valid <= 1'b1;
    wait_sig(0, 2'h2);
    chk_val(outputs_in_reset, 1'b1);
    wait_sig(0, 2'h3);
    chk_val(outputs_in_reset, 1'b0);
    chk_val(out_div_src, 8'hcc);
    chk_val(slew_fast, 8'hf0);
    // forced primary with the select pin high, dividers of ratio two
    wr(plan);
    chk_cfg(cfg_q, plan);
    chk_val(slew_fast, 8'h00);
    chk_val(sel_secondary, 1'b0);
    count_pulses(160);
    chk_val(n_mux inside {[19:21]}, 1'b1);
    chk_val(n_ref inside {[9:11]}, 1'b1);
    chk_val(n_fb inside {[9:11]}, 1'b1);
    chk_val(n_ps inside {[39:41]}, 1'b1);
    // selection by the external pin
    plan.mux_ctrl = 2'h3;
    wr(plan);
    wait_sig(1, 2'h1);
    @(posedge clk);
    ref_sel_pin <= 1'b0;
    wait_sig(1, 2'h0);
    // both automatic codes: pin ignored, primary preferred, loss moves to secondary
    for (int m = 0; m < 2; m++) begin
      plan.mux_ctrl = m[1:0];
      wr(plan);
      @(posedge clk);
      ref_sel_pin <= 1'b1;
      cyc(8);
      #1;
      chk_val(sel_secondary, 1'b0);
      @(posedge clk);
      pri_run <= 1'b0;
      cyc(8);
      #1;
      chk_val(sel_secondary, 1'b0);
      wait_sig(1, 2'h1);
      @(posedge clk);
      pri_run <= 1'b1;
      wait_sig(1, 2'h0);
    end
    // software reset keeps the written plan
    plan = '{2'h2, 4'h3, 14'h0005, 8'h02, 10'h003, 1'b1};
    wr(plan);
    @(posedge clk);
    soft_reset_bit <= 1'b1;
    @(posedge clk);
    soft_reset_bit <= 1'b0;
    wait_sig(0, 2'h1);
    chk_val(outputs_in_reset, 1'b1);
    wait_sig(0, 2'h3);
    chk_cfg(cfg_q, plan);
    // power-down pin low in mid-run, then defaults come back
    @(posedge clk);
    power_down_pin <= 1'b0;
    cyc(3);
    #1;
    chk_val(state_q, 2'h0);
    chk_val(out_pins, 16'h0000);
    @(posedge clk);
    power_down_pin <= 1'b1;
    wait_sig(0, 2'h3);
    chk_cfg(cfg_q, def_cfg);
    end_of_test();
  end
endmodule // smrd_ctrl_bench
